/* File: common/cbas_pkg.sv */
// Constants and types for the charge-balance converter sequencer.
// Assumes a 40 MHz core clock and a 32-bit shift-and-store control chain.
package cbas_pkg;
    localparam int CHAIN_LEN = 32;
    localparam int CNT_W     = 24;
    // Control word field positions
    localparam int FUNC_LSB  = 0;
    localparam int FUNC_W    = 3;
    localparam int RANGE_LSB = 3;
    localparam int RANGE_W   = 3;
    localparam int IN_EN_BIT = 6;
    localparam int DRV_LSB   = 8;
    localparam int DRV_W     = 24;
    // Function codes and the lowest range code
    localparam logic [2:0] FUNC_DCV  = 3'h0;
    localparam logic [2:0] FUNC_ACV  = 3'h1;
    localparam logic [2:0] FUNC_OHMS = 3'h2;
    localparam logic [2:0] FUNC_DCA  = 3'h3;
    localparam logic [2:0] FUNC_ACA  = 3'h4;
    localparam logic [2:0] RANGE_LOW = 3'h0;
    // Reset values
    localparam logic [CHAIN_LEN-1:0] CHAIN_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0]     CNT_RST   = 24'h00_0000;
    localparam logic [1:0]           SYNC_RST  = 2'h0;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CB   = 4'h2,
        ST_FS   = 4'h4,
        ST_DONE = 4'h8
    } cbas_state_t;
endpackage

/* File: common/cbas_chain_if.sv */
// Carrier between the link front end and the shift-and-store chain.
// Both ends run on the core clock.
`timescale 1ns/1ps
interface cbas_chain_if;
    logic                           shift_pulse;
    logic                           shift_bit;
    logic                           strobe_pulse;
    logic [cbas_pkg::CHAIN_LEN-1:0] par_out;
    modport src   (output shift_pulse, output shift_bit, output strobe_pulse, input par_out);
    modport chain (input shift_pulse, input shift_bit, input strobe_pulse, output par_out);
endinterface

/* File: logic/cbas_shift_store.sv */
// Shift-and-store control chain: serial shift stage plus parallel store stage.
// Assumes one-cycle shift and strobe pulses already in the core clock domain.
`timescale 1ns/1ps
module cbas_shift_store
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    // Chain side
    cbas_chain_if.chain ch
);
    logic [cbas_pkg::CHAIN_LEN-1:0] shift_q;
    logic [cbas_pkg::CHAIN_LEN-1:0] store_q;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            shift_q <= cbas_pkg::CHAIN_RST;
        else if (ch.shift_pulse)
            shift_q <= {shift_q[cbas_pkg::CHAIN_LEN-2:0], ch.shift_bit}; // [R8]
    end

    // Store stage moves only on strobe, so drivers never see a half-shifted pattern
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            store_q <= cbas_pkg::CHAIN_RST;
        else if (ch.strobe_pulse)
            store_q <= shift_q; // [R9]
    end

    assign ch.par_out = store_q;

    property p_hold_while_shift;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ch.shift_pulse && !ch.strobe_pulse) |=> $stable(store_q);
    endproperty
    a_hold_while_shift: assert property (p_hold_while_shift) // [R8]
        else $error("Parallel outputs changed while shifting");

    property p_strobe_copy;
        @(posedge i_clk) disable iff (!i_rst_n)
        ch.strobe_pulse |=> (store_q == $past(shift_q));
    endproperty
    a_strobe_copy: assert property (p_strobe_copy) // [R9]
        else $error("Strobe did not transfer the whole shift stage");
endmodule // cbas_shift_store

/* File: logic/cbas_sequencer.sv */
// Analog-side control and charge-balance converter sequencer.
// Assumes the link and comparator inputs are asynchronous to I_CORE_CLK.
//
// Function
// R1 - Gain ten on lowest DCV, lowest ohms and all DCA; otherwise one.
// R2 - Charge-balance phase starts only when software raises input enable.
// R3 - Charge-balance phase counts duty-cycle comparator feedback pulses.
// R4 - After charge balance, balance switch off and final-slope path on.
// R5 - Final slope counts converter clock cycles while its comparator is high.
// R6 - Final slope stops when comparator falls; both counts then valid.
// R7 - Host drives separate clock, data and strobe across isolation.
// R8 - Bits shift in one per clock without disturbing parallel outputs.
// R9 - Strobe moves the whole chain to its outputs at one moment.
// R10 - Host strobes only after a full chain length has been shifted.
`timescale 1ns/1ps
module cbas_sequencer
(
    // Clock and reset
    input  wire logic                        I_CORE_CLK,
    input  wire logic                        I_RST_N,
    // Isolated control link
    input  wire logic                        I_LINK_CLK,
    input  wire logic                        I_LINK_DATA,
    input  wire logic                        I_LINK_STROBE,
    // Converter inputs
    input  wire logic                        I_CONV_CLK,
    input  wire logic                        I_DUTY_CYCLE_COMPARATOR,
    input  wire logic                        I_FINAL_SLOPE_COMPARATOR,
    // Analog controls
    output logic [cbas_pkg::DRV_W-1:0]       O_SWITCH_DRIVE,
    output logic                             O_GAIN_X10,
    output logic                             O_INPUT_ENABLE,
    output logic                             O_CHARGE_BALANCE_SWITCH,
    output logic                             O_FINAL_SLOPE_PATH,
    // Results
    output logic [cbas_pkg::CNT_W-1:0]       O_CB_COUNT,
    output logic [cbas_pkg::CNT_W-1:0]       O_FS_COUNT,
    output logic                             O_READING_READY
);
    cbas_chain_if ch ();

    // Two-flop synchronisers; stage one is read only by stage two
    logic       lclk_s1_q, lclk_s2_q;
    logic       lclk_s3_q;
    logic       ldata_s1_q, ldata_s2_q;
    logic       lstb_s1_q, lstb_s2_q, lstb_s3_q;
    logic       cclk_s1_q, cclk_s2_q, cclk_s3_q;
    logic       duty_s1_q, duty_s2_q, duty_s3_q;
    logic       fs_s1_q, fs_s2_q;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            lclk_s1_q  <= 1'b0;
            lclk_s2_q  <= 1'b0;
            lclk_s3_q  <= 1'b0;
            ldata_s1_q <= 1'b0;
            ldata_s2_q <= 1'b0;
            lstb_s1_q  <= 1'b0;
            lstb_s2_q  <= 1'b0;
            lstb_s3_q  <= 1'b0;
            cclk_s1_q  <= 1'b0;
            cclk_s2_q  <= 1'b0;
            cclk_s3_q  <= 1'b0;
            duty_s1_q  <= 1'b0;
            duty_s2_q  <= 1'b0;
            duty_s3_q  <= 1'b0;
            fs_s1_q    <= 1'b0;
            fs_s2_q    <= 1'b0;
        end
        else
        begin
            lclk_s1_q  <= I_LINK_CLK;
            lclk_s2_q  <= lclk_s1_q;
            lclk_s3_q  <= lclk_s2_q;
            ldata_s1_q <= I_LINK_DATA;
            ldata_s2_q <= ldata_s1_q;
            lstb_s1_q  <= I_LINK_STROBE;
            lstb_s2_q  <= lstb_s1_q;
            lstb_s3_q  <= lstb_s2_q;
            cclk_s1_q  <= I_CONV_CLK;
            cclk_s2_q  <= cclk_s1_q;
            cclk_s3_q  <= cclk_s2_q;
            duty_s1_q  <= I_DUTY_CYCLE_COMPARATOR;
            duty_s2_q  <= duty_s1_q;
            duty_s3_q  <= duty_s2_q;
            fs_s1_q    <= I_FINAL_SLOPE_COMPARATOR;
            fs_s2_q    <= fs_s1_q;
        end
    end

    // Data is taken on the link clock's rising edge; it is stable by then
    logic lclk_rise, lstb_rise, cclk_rise, duty_rise;
    assign lclk_rise = lclk_s2_q && !lclk_s3_q;
    assign lstb_rise = lstb_s2_q && !lstb_s3_q;
    assign cclk_rise = cclk_s2_q && !cclk_s3_q;
    assign duty_rise = duty_s2_q && !duty_s3_q;

    assign ch.shift_pulse  = lclk_rise;   // [R8]
    assign ch.shift_bit    = ldata_s2_q;
    assign ch.strobe_pulse = lstb_rise;   // [R9]

    cbas_shift_store u_chain
    (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .ch      (ch)
    );

    // Decoded control word
    logic [2:0] func_w, range_w;
    logic       in_en;
    assign func_w  = ch.par_out[cbas_pkg::FUNC_LSB +: cbas_pkg::FUNC_W];
    assign range_w = ch.par_out[cbas_pkg::RANGE_LSB +: cbas_pkg::RANGE_W];
    assign in_en   = ch.par_out[cbas_pkg::IN_EN_BIT];

    function automatic logic gain_ten(input logic [2:0] f, input logic [2:0] r);
        gain_ten = (f == cbas_pkg::FUNC_DCA)
                || ((f == cbas_pkg::FUNC_DCV || f == cbas_pkg::FUNC_OHMS)
                    && r == cbas_pkg::RANGE_LOW);
    endfunction

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_SWITCH_DRIVE <= '0;
            O_GAIN_X10     <= 1'b0;
            O_INPUT_ENABLE <= 1'b0;
        end
        else
        begin
            O_SWITCH_DRIVE <= ch.par_out[cbas_pkg::DRV_LSB +: cbas_pkg::DRV_W]; // [R9]
            O_GAIN_X10     <= gain_ten(func_w, range_w); // [R1]
            O_INPUT_ENABLE <= in_en;
        end
    end

    // Phase sequencer; software times the settling delay before raising enable
    cbas_pkg::cbas_state_t state_q, state_d;
    logic in_en_q;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            in_en_q <= 1'b0;
        else
            in_en_q <= in_en;
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cbas_pkg::ST_IDLE,
            cbas_pkg::ST_DONE:
                if (in_en && !in_en_q)
                    state_d = cbas_pkg::ST_CB; // [R2]
            cbas_pkg::ST_CB:
                if (!in_en)
                    state_d = cbas_pkg::ST_FS; // [R4]
            cbas_pkg::ST_FS:
                if (!fs_s2_q)
                    state_d = cbas_pkg::ST_DONE; // [R6]
            default:
                state_d = cbas_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            state_q <= cbas_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    // Counters restart on each new conversion
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            O_CB_COUNT <= cbas_pkg::CNT_RST;
        else if (state_q != cbas_pkg::ST_CB && state_d == cbas_pkg::ST_CB)
            O_CB_COUNT <= cbas_pkg::CNT_RST;
        else if (state_q == cbas_pkg::ST_CB && duty_rise)
            O_CB_COUNT <= O_CB_COUNT + 1'b1; // [R3]
    end

    // Gated converter clock count; a wrap is a limitation, not flagged
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            O_FS_COUNT <= cbas_pkg::CNT_RST;
        else if (state_q != cbas_pkg::ST_CB && state_d == cbas_pkg::ST_CB)
            O_FS_COUNT <= cbas_pkg::CNT_RST;
        else if (state_q == cbas_pkg::ST_FS && fs_s2_q && cclk_rise)
            O_FS_COUNT <= O_FS_COUNT + 1'b1; // [R5]
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_CHARGE_BALANCE_SWITCH <= 1'b0;
            O_FINAL_SLOPE_PATH      <= 1'b0;
            O_READING_READY         <= 1'b0;
        end
        else
        begin
            O_CHARGE_BALANCE_SWITCH <= (state_d == cbas_pkg::ST_CB); // [R4]
            O_FINAL_SLOPE_PATH      <= (state_d == cbas_pkg::ST_FS); // [R4]
            O_READING_READY         <= (state_d == cbas_pkg::ST_DONE); // [R6]
        end
    end

    // Checks
    property p_gain;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        // Written out from the field codes, not the decode function, to catch a bad decode
        1'b1 |=> (O_GAIN_X10 == $past((func_w == cbas_pkg::FUNC_DCA)
                                      || (func_w == cbas_pkg::FUNC_DCV
                                          && range_w == cbas_pkg::RANGE_LOW)
                                      || (func_w == cbas_pkg::FUNC_OHMS
                                          && range_w == cbas_pkg::RANGE_LOW)));
    endproperty
    a_gain: assert property (p_gain) // [R1]
        else $error("Gain select does not match function and range");

    sequence s_enable_rise;
        (state_q == cbas_pkg::ST_IDLE || state_q == cbas_pkg::ST_DONE) && in_en && !in_en_q;
    endsequence
    property p_start;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        s_enable_rise |=> (state_q == cbas_pkg::ST_CB) ##0 O_CHARGE_BALANCE_SWITCH;
    endproperty
    a_start: assert property (p_start) // [R2]
        else $error("Charge balance did not start on input enable");

    property p_no_start;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (state_q == cbas_pkg::ST_IDLE && !in_en) |=> state_q == cbas_pkg::ST_IDLE;
    endproperty
    a_no_start: assert property (p_no_start) // [R2]
        else $error("Conversion started without input enable");

    property p_cb_count;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (state_q == cbas_pkg::ST_CB && state_d == cbas_pkg::ST_CB && duty_rise)
            |=> O_CB_COUNT == $past(O_CB_COUNT) + 1'b1;
    endproperty
    a_cb_count: assert property (p_cb_count) // [R3]
        else $error("Charge balance pulse not counted");

    sequence s_cb_end;
        state_q == cbas_pkg::ST_CB && !in_en;
    endsequence
    property p_handover;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        s_cb_end |=> !O_CHARGE_BALANCE_SWITCH && (O_FINAL_SLOPE_PATH || O_READING_READY);
    endproperty
    a_handover: assert property (p_handover) // [R4]
        else $error("Feedback path not handed to final slope");

    property p_fs_count;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (state_q == cbas_pkg::ST_FS && fs_s2_q && cclk_rise)
            |=> O_FS_COUNT == $past(O_FS_COUNT) + 1'b1;
    endproperty
    a_fs_count: assert property (p_fs_count) // [R5]
        else $error("Gated converter clock not counted");

    property p_stop;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        (state_q == cbas_pkg::ST_FS && !fs_s2_q)
            |=> O_READING_READY && $stable(O_FS_COUNT) && $stable(O_CB_COUNT);
    endproperty
    a_stop: assert property (p_stop) // [R6]
        else $error("Final slope did not stop on comparator fall");
endmodule // cbas_sequencer

/* File: tb/cbas_host_link.sv */
// Host-side link model: shifts control words and strobes them across the barrier.
// Assumes the core clock is used only to pace its own edges.
`timescale 1ns/1ps
module cbas_host_link
(
    // Pacing clock
    input  wire logic i_clk,
    // Link pins
    output logic      o_link_clk,
    output logic      o_link_data,
    output logic      o_link_strobe
);
    initial
    begin
        o_link_clk    = 1'b0;
        o_link_data   = 1'b0;
        o_link_strobe = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Four core cycles per half period gives the 200 ns link clock
    task automatic shift_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) // Own clock, data and strobe lines
        begin
            wait_cyc(1);
            o_link_data = w[i]; // MSB first, one bit per clock
            wait_cyc(3);
            o_link_clk = 1'b1;
            wait_cyc(4);
            o_link_clk = 1'b0;
        end
        wait_cyc(4);
        // Released line must not show the last bit as if still valid
        o_link_data = ~o_link_data;
    endtask

    task automatic pulse_strobe();
        wait_cyc(4);
        o_link_strobe = 1'b1; // Strobe only after a whole word
        wait_cyc(4);
        o_link_strobe = 1'b0;
    endtask

    task automatic send_word(input logic [31:0] w);
        shift_word(w);
        pulse_strobe();
    endtask
endmodule // cbas_host_link

/* File: tb/cbas_sequencer_tb_top.sv */
// Self-checking bench for the converter sequencer.
// Assumes the host link model and the design's package are compiled first.
`timescale 1ns/1ps
module cbas_sequencer_tb_top;
    logic                         core_clk = 1'b0;
    logic                         rst_n;
    logic                         conv_clk;
    logic                         duty_cmp;
    logic                         fs_cmp;
    wire logic                    link_clk;
    wire logic                    link_data;
    wire logic                    link_strobe;
    logic [cbas_pkg::DRV_W-1:0]   sw_drive;
    logic                         gain_x10;
    logic                         in_en;
    logic                         cb_sw;
    logic                         fs_path;
    logic [cbas_pkg::CNT_W-1:0]   cb_cnt;
    logic [cbas_pkg::CNT_W-1:0]   fs_cnt;
    logic                         ready;
    int                           n_errors = 0;
    int                           n_checks = 0;

    always #12.5 core_clk = ~core_clk;

    cbas_host_link host (.i_clk(core_clk), .o_link_clk(link_clk), .o_link_data(link_data),
                         .o_link_strobe(link_strobe));

    cbas_sequencer uut (
        .I_CORE_CLK(core_clk), .I_RST_N(rst_n), .I_LINK_CLK(link_clk),
        .I_LINK_DATA(link_data), .I_LINK_STROBE(link_strobe), .I_CONV_CLK(conv_clk),
        .I_DUTY_CYCLE_COMPARATOR(duty_cmp), .I_FINAL_SLOPE_COMPARATOR(fs_cmp),
        .O_SWITCH_DRIVE(sw_drive), .O_GAIN_X10(gain_x10), .O_INPUT_ENABLE(in_en),
        .O_CHARGE_BALANCE_SWITCH(cb_sw), .O_FINAL_SLOPE_PATH(fs_path),
        .O_CB_COUNT(cb_cnt), .O_FS_COUNT(fs_cnt), .O_READING_READY(ready));

    function automatic logic [31:0] word(input logic [2:0] f, input logic [2:0] r,
                                         input logic en, input logic [23:0] drv);
        return {drv, 1'b0, en, r, f};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Leaves time for sync, store and the registered gain decode to land
    task automatic load(input logic [31:0] w);
        host.send_word(w);
        repeat (8) @(negedge core_clk);
    endtask

    task automatic pulses(input int n, input bit duty);
        for (int i = 0; i < n; i++)
        begin
            @(negedge core_clk);
            if (duty) duty_cmp = 1'b1;
            else conv_clk = 1'b1;
            repeat (5) @(negedge core_clk);
            if (duty) duty_cmp = 1'b0;
            else conv_clk = 1'b0;
            repeat (4) @(negedge core_clk);
        end
        repeat (4) @(negedge core_clk);
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic test_reset();
        chk({3'h0, sw_drive, gain_x10, in_en, cb_sw, fs_path, ready}, 32'h0000_0000, "reset out");
        chk({8'h00, cb_cnt}, 32'h0000_0000, "reset cb");
        chk({8'h00, fs_cnt}, 32'h0000_0000, "reset fs");
    endtask

    task automatic test_gain();
        logic [2:0]  f [7];
        logic [2:0]  r [7];
        logic        g [7];
        logic [23:0] drv;
        f = '{cbas_pkg::FUNC_DCV, cbas_pkg::FUNC_DCV, cbas_pkg::FUNC_ACV, cbas_pkg::FUNC_OHMS,
              cbas_pkg::FUNC_OHMS, cbas_pkg::FUNC_DCA, cbas_pkg::FUNC_ACA};
        r = '{3'h0, 3'h5, 3'h0, 3'h0, 3'h3, 3'h4, 3'h0};
        g = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 7; i++)
        begin
            drv = {8'h5A, 8'(i), 8'hC3};
            load(word(f[i], r[i], 1'b0, drv));
            chk({31'h0, gain_x10}, {31'h0, g[i]}, "gain");
            chk({8'h00, sw_drive}, {8'h00, drv}, "drive");
        end
    endtask

    task automatic test_shift_hold();
        logic moved;
        moved = 1'b0;
        load(word(cbas_pkg::FUNC_OHMS, cbas_pkg::RANGE_LOW, 1'b0, 24'h12_3456));
        fork
            host.shift_word(word(cbas_pkg::FUNC_ACV, 3'h2, 1'b0, 24'hED_CBA9));
            repeat (270) @(negedge core_clk) if (sw_drive !== 24'h12_3456) moved = 1'b1;
        join
        chk({31'h0, moved}, 32'h0000_0000, "moved in shift");
        chk({31'h0, gain_x10}, 32'h0000_0001, "gain in shift");
        host.pulse_strobe();
        repeat (8) @(negedge core_clk);
        chk({8'h00, sw_drive}, 32'h00ED_CBA9, "drive stored");
        chk({31'h0, gain_x10}, 32'h0000_0000, "gain stored");
    endtask

    task automatic test_conversion();
        @(negedge core_clk) fs_cmp = 1'b1;
        load(word(cbas_pkg::FUNC_DCV, 3'h1, 1'b1, 24'h00_0F00));
        chk({30'h0, in_en, cb_sw}, 32'h0000_0003, "cb start");
        chk({30'h0, fs_path, ready}, 32'h0000_0000, "cb only");
        pulses(3, 1'b0);
        pulses(7, 1'b1);
        chk({8'h00, cb_cnt}, 32'h0000_0007, "cb count");
        chk({8'h00, fs_cnt}, 32'h0000_0000, "fs idle");
        load(word(cbas_pkg::FUNC_DCV, 3'h1, 1'b0, 24'h00_0F00));
        chk({30'h0, cb_sw, fs_path}, 32'h0000_0001, "to fs");
        pulses(2, 1'b1);
        pulses(9, 1'b0);
        chk({8'h00, cb_cnt}, 32'h0000_0007, "cb held");
        chk({8'h00, fs_cnt}, 32'h0000_0009, "fs count");
        @(negedge core_clk) fs_cmp = 1'b0;
        repeat (6) @(negedge core_clk);
        chk({30'h0, fs_path, ready}, 32'h0000_0001, "fs end");
        pulses(2, 1'b0);
        chk({8'h00, fs_cnt}, 32'h0000_0009, "fs frozen");
        chk({8'h00, cb_cnt}, 32'h0000_0007, "cb frozen");
        load(word(cbas_pkg::FUNC_DCV, 3'h1, 1'b1, 24'h00_0F00));
        chk({29'h0, cb_sw, ready, fs_cnt == 24'h0}, 32'h0000_0005, "restart");
        pulses(4, 1'b1);
        load(word(cbas_pkg::FUNC_DCA, 3'h1, 1'b1, 24'h00_0F00));
        chk({8'h00, cb_cnt}, 32'h0000_0004, "no restart");
        load(word(cbas_pkg::FUNC_DCV, 3'h1, 1'b0, 24'h00_0F00));
        chk({29'h0, cb_sw, fs_path, ready}, 32'h0000_0001, "fs already low");
        chk({8'h00, fs_cnt}, 32'h0000_0000, "fs none");
    endtask

    initial
    begin
        rst_n    = 1'b0;
        conv_clk = 1'b0;
        duty_cmp = 1'b0;
        fs_cmp   = 1'b0;
        repeat (5) @(negedge core_clk);
        test_reset();
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        test_gain();
        test_shift_hold();
        test_conversion();
        final_report();
    end

    // Whole run needs about 105 us; nearly ten times that marks a hang
    initial
    begin
        #1_000_000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule // cbas_sequencer_tb_top
